// ---- hw/rpm_cfg.svh ----
`ifndef RPM_CFG_SVH
`define RPM_CFG_SVH
// Operation
// - Any reset drives the reset pin low about 66 bus cycles, then releases.
// - Reset cause is decoded and its flag set in the cause register.
// - External low on the reset pin requests a reset.
// - Background pin selects mode in reset, serves debug link afterwards.
// - Pin left open reads high through pullup: normal mode at release.
// - Pin held low at reset release starts active background mode.
// - Each debug bit time spans 16 debug controller clock cycles.
// - Debug controller clock may run at the full bus clock rate.
// - Pin is pseudo open-drain; releasing side drives brief high speedup.
// - After reset the clock source is the internal generator.
`define RPM_RST_LOW_CYC 7'd66
`define RPM_CNT_W 7
`define RPM_BIT_CYC 5'd16
`define RPM_SPEEDUP_CYC 5'd1
`define RPM_SAMPLE_CYC 5'd10
`define RPM_START_LOW_CYC 5'd4
`define RPM_ZERO_END_CYC 5'd13
`define RPM_CAUSE_POR 0
`define RPM_CAUSE_PIN 1
`define RPM_CAUSE_COP 2
`define RPM_CAUSE_ILOP 3
`define RPM_CAUSE_ILAD 4
`define RPM_CAUSE_LVD 5
`define RPM_CAUSE_W 8
`define RPM_CAUSE_RST 8'h01
`endif

// ---- hw/rpm_pkg.sv ----
package rpm_pkg;
  typedef enum logic [1:0] {
    RPM_ST_POR,
    RPM_ST_DRIVE,
    RPM_ST_WAIT_REL,
    RPM_ST_RUN
  } rpm_state_t;
  typedef enum logic {
    RPM_MODE_NORMAL,
    RPM_MODE_BKGD
  } rpm_mode_t;
  typedef enum logic {
    RPM_CLK_INTERNAL,
    RPM_CLK_EXTERNAL
  } rpm_clk_t;
endpackage

// ---- hw/rpm_bit_timer.sv ----
`timescale 1ns/100ps
`include "rpm_cfg.svh"
module rpm_bit_timer
  import rpm_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic bit_tick,
  // Status
  output logic busy,
  output logic [4:0] phase
);
  // ---------------------------------------------
  // Bit time counter
  // ---------------------------------------------
  // Sixteen-cycle bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      phase <= 5'h00;
    end else if (start && !busy) begin
      busy <= 1'b1;
      phase <= 5'h00;
    end else if (busy && bit_tick) begin
      if (phase == `RPM_BIT_CYC - 5'd1) begin
        busy <= 1'b0;
        phase <= 5'h00;
      end else begin
        phase <= phase + 5'd1;
      end
    end
  end
endmodule

// ---- hw/rpm_reset_mode.sv ----
`timescale 1ns/100ps
`include "rpm_cfg.svh"
module rpm_reset_mode
  import rpm_pkg::*;
(
  // Clock and power-on reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Internal reset sources, one-cycle pulses
  input wire logic cop_rst,
  input wire logic ilop_rst,
  input wire logic ilad_rst,
  input wire logic lvd_rst,
  // Reset pin
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  // Background mode select pin
  input wire logic background_mode_select_pin_in,
  output logic background_mode_select_pin_out,
  output logic background_mode_select_pin_oe,
  // Debug link user side
  input wire logic dbg_tx_req,
  input wire logic dbg_tx_bit,
  output logic dbg_tx_done,
  output logic dbg_rx_bit,
  output logic dbg_rx_valid,
  // System status
  output logic sys_reset_n,
  output logic bkgd_mode,
  output logic clk_sel_ext,
  output logic [7:0] reset_cause_register
);
  rpm_state_t state_r;
  logic [6:0] cnt_r;
  logic [7:0] cause_nxt;
  logic int_src;
  logic bt_busy;
  logic [4:0] bt_phase;
  logic tx_bit_r;
  logic busy_d_r;
  logic bkgd_idle;
  logic rst_req;
  logic lo_phase;
  logic hi_phase;

  assign int_src = cop_rst | ilop_rst | ilad_rst | lvd_rst;
  assign bkgd_idle = (state_r == RPM_ST_RUN);
  assign rst_req = bkgd_idle && (int_src || !reset_pin_in);

  // ---------------------------------------------
  // Reset cause decode
  // ---------------------------------------------
  always_comb begin
    cause_nxt = 8'h00;
    cause_nxt[`RPM_CAUSE_COP] = cop_rst;
    cause_nxt[`RPM_CAUSE_ILOP] = ilop_rst;
    cause_nxt[`RPM_CAUSE_ILAD] = ilad_rst;
    cause_nxt[`RPM_CAUSE_LVD] = lvd_rst;
    if (!int_src) begin
      cause_nxt[`RPM_CAUSE_PIN] = 1'b1;
    end
  end

  // ---------------------------------------------
  // Reset sequencer
  // ---------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RPM_ST_POR;
      cnt_r <= 7'h00;
      reset_cause_register <= `RPM_CAUSE_RST;
    end else begin
      case (state_r)
        RPM_ST_POR: begin
          state_r <= RPM_ST_DRIVE;
          cnt_r <= 7'h00;
        end
        RPM_ST_DRIVE: begin
          if (cnt_r == `RPM_RST_LOW_CYC - 7'd1) begin
            state_r <= RPM_ST_WAIT_REL;
          end else begin
            cnt_r <= cnt_r + 7'd1;
          end
        end
        RPM_ST_WAIT_REL: begin
          if (reset_pin_in) begin
            state_r <= RPM_ST_RUN;
          end
        end
        RPM_ST_RUN: begin
          if (rst_req) begin
            state_r <= RPM_ST_DRIVE;
            cnt_r <= 7'h00;
            reset_cause_register <= cause_nxt;
          end
        end
        default: begin
          state_r <= RPM_ST_POR;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // Reset pin and system reset
  // ---------------------------------------------
  // Drive low then release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      sys_reset_n <= 1'b0;
    end else begin
      reset_pin_out <= 1'b0;
      reset_pin_oe <= (state_r == RPM_ST_POR) ||
        (state_r == RPM_ST_DRIVE);
      sys_reset_n <= (state_r == RPM_ST_WAIT_REL) && reset_pin_in;
      if (bkgd_idle && !rst_req) begin
        sys_reset_n <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Mode select and clock source
  // ---------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bkgd_mode <= 1'b0;
      clk_sel_ext <= 1'b0;
    end else if (state_r == RPM_ST_WAIT_REL && reset_pin_in) begin
      bkgd_mode <= !background_mode_select_pin_in;
      clk_sel_ext <= RPM_CLK_INTERNAL;
    end
  end

  // ---------------------------------------------
  // Background debug link
  // ---------------------------------------------
  // Bit timing on bus clock
  rpm_bit_timer u_bit_timer (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .start(bkgd_idle && dbg_tx_req),
    .bit_tick(1'b1),
    .busy(bt_busy),
    .phase(bt_phase)
  );

  // ---------------------------------------------
  // Debug link status
  // ---------------------------------------------
  // Sample mid bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_bit_r <= 1'b1;
      busy_d_r <= 1'b0;
      dbg_tx_done <= 1'b0;
      dbg_rx_bit <= 1'b1;
      dbg_rx_valid <= 1'b0;
    end else begin
      busy_d_r <= bt_busy;
      dbg_tx_done <= busy_d_r && !bt_busy;
      dbg_rx_valid <= 1'b0;
      if (bkgd_idle && dbg_tx_req && !bt_busy) begin
        tx_bit_r <= dbg_tx_bit;
      end
      if (bkgd_idle && bt_busy && bt_phase == `RPM_SAMPLE_CYC) begin
        dbg_rx_bit <= background_mode_select_pin_in;
        dbg_rx_valid <= 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Bit waveform decode
  // ---------------------------------------------
  // Low drive, then speedup
  always_comb begin
    lo_phase = 1'b0;
    hi_phase = 1'b0;
    if (bt_phase < `RPM_START_LOW_CYC) begin
      lo_phase = 1'b1;
    end else if (bt_phase < `RPM_START_LOW_CYC + `RPM_SPEEDUP_CYC) begin
      hi_phase = 1'b1;
    end else if (!tx_bit_r && bt_phase < `RPM_ZERO_END_CYC) begin
      lo_phase = 1'b1;
    end else if (!tx_bit_r &&
        bt_phase < `RPM_ZERO_END_CYC + `RPM_SPEEDUP_CYC) begin
      hi_phase = 1'b1;
    end
  end

  // ---------------------------------------------
  // Background pin driver
  // ---------------------------------------------
  // Pin is input during reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      background_mode_select_pin_out <= 1'b0;
      background_mode_select_pin_oe <= 1'b0;
    end else if (!bkgd_idle || rst_req || !bt_busy) begin
      background_mode_select_pin_out <= 1'b0;
      background_mode_select_pin_oe <= 1'b0;
    end else begin
      background_mode_select_pin_out <= hi_phase;
      background_mode_select_pin_oe <= lo_phase || hi_phase;
    end
  end
endmodule

// ---- dv/rpm_reset_mode_props.sv ----
`timescale 1ns/100ps
module rpm_reset_mode_props (
  // Clock and pins
  input logic sys_clk,
  input logic rst_n,
  input logic reset_pin_in,
  input logic reset_pin_oe,
  input logic background_mode_select_pin_in,
  input logic background_mode_select_pin_out,
  input logic background_mode_select_pin_oe,
  // Status
  input logic dbg_tx_req,
  input logic dbg_tx_done,
  input logic sys_reset_n,
  input logic bkgd_mode,
  input logic clk_sel_ext,
  input logic [7:0] reset_cause_register
);
  logic [7:0] cnt_r;
  wire ms_oe = background_mode_select_pin_oe;
  wire ms_lo = ms_oe && !background_mode_select_pin_out;
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n) cnt_r <= 8'h00;
    else cnt_r <= reset_pin_oe ? cnt_r + 8'h01 : 8'h00;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_drive_len: assert property ($fell(reset_pin_oe) |->
    cnt_r >= 8'd66 && cnt_r <= 8'd68) else $error("drive");
  a_pin_req: assert property (sys_reset_n && !reset_pin_in |->
    ##[1:3] reset_pin_oe) else $error("request");
  a_cause_flag: assert property ($rose(sys_reset_n) |->
    $onehot(reset_cause_register)) else $error("cause");
  a_mode_pick: assert property ($rose(sys_reset_n) |->
    bkgd_mode == !$past(background_mode_select_pin_in)) else $error("mode");
  a_pin_quiet: assert property (!sys_reset_n |-> !ms_oe)
    else $error("quiet");
  a_clk_int: assert property ($rose(sys_reset_n) |-> !clk_sel_ext)
    else $error("clock");
  a_speedup_pulse: assert property (ms_lo ##1 !ms_lo |-> ms_oe)
    else $error("speedup");
  a_bit_time: assert property ($rose(dbg_tx_req) |->
    !dbg_tx_done [*8] ##[7:12] dbg_tx_done) else $error("bit");
  c_mode_bg: cover property ($rose(sys_reset_n) && bkgd_mode);
  c_mode_run: cover property ($rose(sys_reset_n) && !bkgd_mode);
  c_bit: cover property (dbg_tx_done);
endmodule
bind rpm_reset_mode rpm_reset_mode_props rpm_reset_mode_props_inst (.*);

// ---- dv/rpm_pod.sv ----
`timescale 1ns/100ps
module rpm_pod (
  // Clock and commands
  input logic sys_clk,
  input logic hold,
  input logic press,
  // Pin drive
  output logic p_oe,
  output logic p_out,
  output logic sw_low
);
  logic hold_r = 1'h0;
  logic [2:0] sw_r = 3'h0;
  // Low on bus clock, speedup at release
  always @(posedge sys_clk) hold_r <= hold;
  assign p_oe = hold | hold_r;
  assign p_out = !hold;
  always @(posedge sys_clk) sw_r <= press ? 3'h4 : sw_r - 3'(sw_r != 0);
  assign sw_low = sw_r != 3'h0;
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
module testbench;
  logic sys_clk = 0, rst_n = 0, hold = 0, press = 0, sw_low, p_oe, p_out;
  logic cop_rst = 0, ilop_rst = 0, ilad_rst = 0, lvd_rst = 0;
  logic dbg_tx_req = 0, dbg_tx_bit = 0, dbg_tx_done, dbg_rx_bit, dbg_rx_valid;
  logic sys_reset_n, bkgd_mode, clk_sel_ext, reset_pin_in, reset_pin_out;
  logic reset_pin_oe, background_mode_select_pin_oe;
  logic background_mode_select_pin_in, background_mode_select_pin_out;
  logic [7:0] reset_cause_register;
  int n_errors = 0, cmp_count = 0, n_low = 0, i, ex[$];
  always #25 sys_clk = ~sys_clk;
  assign reset_pin_in = reset_pin_oe ? reset_pin_out : !sw_low;
  assign background_mode_select_pin_in = background_mode_select_pin_oe ?
    background_mode_select_pin_out : !p_oe | p_out;
  rpm_reset_mode rpm_reset_mode_inst (.*);
  rpm_pod rpm_pod_inst (.*);
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wait_srn(logic v);
    for (int k = 0; k < 300 && sys_reset_n !== v; k++) tick(1);
    chk("srn", sys_reset_n, v);
  endtask
  task automatic after_rst(logic [7:0] c, logic h);
    wait_srn(1);
    chk("cause", reset_cause_register, c);
    chk("mode", bkgd_mode, h);
    chk("clk", clk_sel_ext, 8'h00);
    tick(4);
    hold = 0;
  endtask
  always @(negedge sys_clk)
    if (reset_pin_oe === 1'b1) n_low++;
  always @(negedge sys_clk)
    if (dbg_rx_valid === 1 && ex.size() > 0)
      chk("rx", dbg_rx_bit, 8'(ex.pop_front()));
  initial begin
    #400000 n_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(74));
    tick(16);
    rst_n = 1;
    after_rst(8'h01, 0);
    for (i = 0; i < 5; i++) begin
      hold = i[0];
      n_low = 0;
      {press, lvd_rst, ilad_rst, ilop_rst, cop_rst} = 5'h01 << i;
      tick(1);
      {press, lvd_rst, ilad_rst, ilop_rst, cop_rst} = 5'h00;
      wait_srn(0);
      after_rst(i < 4 ? 8'h04 << i : 8'h02, i[0]);
      chk("low", 8'(n_low), 8'd66);
    end
    for (i = 0; i < 8; i++) begin
      dbg_tx_bit = 1'($urandom);
      hold = 1'($urandom);
      ex.push_back(dbg_tx_bit & !hold);
      dbg_tx_req = 1;
      tick(1);
      dbg_tx_req = 0;
      for (int k = 0; k < 40 && dbg_tx_done !== 1; k++) tick(1);
      chk("done", dbg_tx_done, 8'h01);
      tick(1);
    end
    chk("rx left", 8'(ex.size()), 8'h00);
    finish_test();
  end
endmodule
